// >>> hia_defines.svh
// Offsets, bit positions, reset values and event indexes of the host interrupt aggregator
`ifndef HIA_DEFINES_SVH
`define HIA_DEFINES_SVH

// Register byte offsets
`define HIA_OFS_STATUS 12'h000
`define HIA_OFS_CMD 12'h008
`define HIA_OFS_MASK 12'h00C

// Reset values
`define HIA_MASK_RESET 32'h00F4FF3F
`define HIA_ZERO_WORD 32'h00000000

// Source status and mask field positions (shared layout)
`define HIA_BIT_ENABLE 31
`define HIA_BIT_MIDI 22
`define HIA_BIT_FIFO_SUM 20
`define HIA_BIT_DMA_SUM 18
`define HIA_FIFO_LSB 12
`define HIA_DMA_LSB 8
`define HIA_PIN_LSB 0

// Command register fields and the two software commands
`define HIA_CMD_VALUE_BIT 0
`define HIA_CMD_STROBE_BIT 1
`define HIA_CMD_EOI 32'h00000003
`define HIA_CMD_DISABLE 32'h00000002

// Pin group index (status bits 5..0)
`define HIA_PIN_VDN 0
`define HIA_PIN_VUP 1
`define HIA_PIN_GP1 2
`define HIA_PIN_GP3 3
`define HIA_PIN_GPS 4
`define HIA_PIN_GPP 5
`define HIA_PIN_COUNT 6

// Event latch vector layout
`define HIA_EV_PIN_LSB 0
`define HIA_EV_DMA_LSB 6
`define HIA_EV_FIFO_LSB 10
`define HIA_EV_MIDI 14
`define HIA_EV_COUNT 15

`endif

// >>> hia_pkg.sv
// Types shared by the host interrupt aggregator files
package hia_pkg;

  typedef logic [31:0] hia_word_t;

  typedef enum logic [1:0] {
    HIA_SEL_STATUS = 2'b00,
    HIA_SEL_CMD = 2'b01,
    HIA_SEL_MASK = 2'b10,
    HIA_SEL_NONE = 2'b11
  } hia_sel_e;

endpackage

// >>> hia_event_latch.sv
// Sticky event flags with per-bit clear where a new event beats its clear
`timescale 1ns/10ps
module hia_event_latch #(
  parameter int WIDTH = 15
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clear_in,
  output logic [WIDTH-1:0] flag_out
);

  logic [WIDTH-1:0] flag_q;
  logic [WIDTH-1:0] flag_d;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("hia_event_latch needs at least one flag");
    end
  endgenerate

  // Set is ORed in after the clear so a same-cycle event survives
  assign flag_d = (flag_q & ~clear_in) | set_in;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_out = flag_q;

endmodule

// >>> hia_top.sv
// Host interrupt aggregator: source latches, status, command and mask registers, host line
`timescale 1ns/10ps
`include "hia_defines.svh"
module hia_top
  import hia_pkg::*;
#(
  parameter int N_DMA = 4,
  parameter int N_FIFO = 4
) (
  input wire logic CORE_CLK_IN,
  input wire logic SRST_IN,
  // Host register port
  input wire logic [11:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [31:0] REG_WDATA_IN,
  output logic [31:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  // DMA engines: event pulses and status-read strobes
  input wire logic [N_DMA-1:0] DMA_EVENT_IN,
  input wire logic [N_DMA-1:0] DMA_STATUS_READ_IN,
  // Polled FIFOs: event pulses and status-read strobes
  input wire logic [N_FIFO-1:0] FIFO_EVENT_IN,
  input wire logic [N_FIFO-1:0] FIFO_IRQ_STATUS_READ_IN,
  // MIDI receiver
  input wire logic MIDI_RX_DATA_IN,
  input wire logic MIDI_PORT_STATUS_READ_IN,
  // Codec slot 12 GP_INT bits
  input wire logic PRIMARY_GP_INT_IN,
  input wire logic SECONDARY_GP_INT_IN,
  // Pin levels
  input wire logic PIN3_IN,
  input wire logic PIN1_IN,
  input wire logic VOL_UP_PIN_IN,
  input wire logic VOL_DOWN_PIN_IN,
  // Pin event control fields held outside this block
  input wire logic PIN3_OUTPUT_ENABLE_IN,
  input wire logic PIN1_OUTPUT_ENABLE_IN,
  input wire logic PIN3_STICKY_IN,
  input wire logic PIN1_STICKY_IN,
  input wire logic VOL_UP_STICKY_IN,
  input wire logic VOL_DOWN_STICKY_IN,
  input wire logic VOL_UP_LATCH_TRIGGER_IN,
  input wire logic VOL_DOWN_LATCH_TRIGGER_IN,
  input wire logic PIN1_SECONDARY_CODEC_IN,
  input wire logic HW_VOLUME_ENABLE_IN,
  input wire logic HW_VOLUME_UPDATE_IN,
  input wire logic [5:0] PIN_EVENT_CLEAR_IN,
  // Sticky state for the pin event control readback
  output logic [5:0] PIN_STICKY_STATUS_OUT,
  // Host interrupt line
  output logic HOST_IRQ_N_OUT
);

  // The status word has fixed room for exactly four DMA and four FIFO sources
  generate
    if (N_DMA != 4 || N_FIFO != 4) begin : g_bad_params
      $error("hia_top status layout holds exactly four DMA and four FIFO sources");
    end
  endgenerate

  // Full 12-bit match, so aliases of the three offsets read as unmapped
  function automatic hia_sel_e reg_sel(input logic [11:0] addr);
    hia_sel_e sel;
    sel = HIA_SEL_NONE;
    case (addr)
      `HIA_OFS_STATUS: sel = HIA_SEL_STATUS;
      `HIA_OFS_CMD: sel = HIA_SEL_CMD;
      `HIA_OFS_MASK: sel = HIA_SEL_MASK;
      default: sel = HIA_SEL_NONE;
    endcase
    return sel;
  endfunction

  // Any-edge detector on a level, suppressed until history is valid
  function automatic logic toggled(input logic now_lvl, input logic was_lvl,
                                   input logic valid);
    return valid & (now_lvl ^ was_lvl);
  endfunction

  // Register state
  logic enable_q;
  logic enable_d;
  hia_word_t mask_q;
  hia_word_t mask_d;
  hia_word_t rdata_q;
  hia_word_t rdata_d;
  logic rvalid_q;
  logic irq_n_q;
  logic irq_n_d;

  // Pin history for edge detection
  logic hist_valid_q;
  logic pin3_prev_q;
  logic pin1_prev_q;
  logic vup_prev_q;
  logic vdn_prev_q;
  logic gpp_prev_q;
  logic gps_prev_q;

  // Decode
  hia_sel_e sel;
  logic wr_cmd;
  logic wr_mask;
  logic rd_status;
  logic rd_cmd;
  logic rd_mask;
  logic cmd_strobe;
  logic cmd_value;

  assign sel = reg_sel(REG_ADDR_IN);
  assign wr_cmd = REG_WR_IN && (sel == HIA_SEL_CMD);
  assign wr_mask = REG_WR_IN && (sel == HIA_SEL_MASK);
  assign rd_status = REG_RD_IN && (sel == HIA_SEL_STATUS);
  assign rd_cmd = REG_RD_IN && (sel == HIA_SEL_CMD);
  assign rd_mask = REG_RD_IN && (sel == HIA_SEL_MASK);
  // Strobe bit is never stored, so it cannot read back as one
  assign cmd_strobe = REG_WDATA_IN[`HIA_CMD_STROBE_BIT];
  assign cmd_value = REG_WDATA_IN[`HIA_CMD_VALUE_BIT];

  // Pin edge events
  logic pin3_edge;
  logic pin1_edge;
  logic vup_edge;
  logic vdn_edge;
  logic gpp_rise;
  logic gps_rise;
  logic vol_engine_up;
  logic vol_engine_dn;

  assign pin3_edge = toggled(PIN3_IN, pin3_prev_q, hist_valid_q);
  assign pin1_edge = toggled(PIN1_IN, pin1_prev_q, hist_valid_q);
  assign vup_edge = toggled(VOL_UP_PIN_IN, vup_prev_q, hist_valid_q);
  assign vdn_edge = toggled(VOL_DOWN_PIN_IN, vdn_prev_q, hist_valid_q);
  // Codec GP_INT counts on its rising edge only; a held level is one event
  assign gpp_rise = hist_valid_q & PRIMARY_GP_INT_IN & ~gpp_prev_q;
  assign gps_rise = hist_valid_q & SECONDARY_GP_INT_IN & ~gps_prev_q;

  // Engine updates skip the sticky bit; only the pin edges need it
  // Engine update fires the volume up and down flags whose latch trigger is set
  assign vol_engine_up = HW_VOLUME_ENABLE_IN & VOL_UP_LATCH_TRIGGER_IN & HW_VOLUME_UPDATE_IN;
  assign vol_engine_dn = HW_VOLUME_ENABLE_IN & VOL_DOWN_LATCH_TRIGGER_IN & HW_VOLUME_UPDATE_IN;

  logic [5:0] pin_set;
  // Input and sticky needed on GPIO pins
  assign pin_set[`HIA_PIN_GP3] = pin3_edge & ~PIN3_OUTPUT_ENABLE_IN & PIN3_STICKY_IN;
  assign pin_set[`HIA_PIN_GP1] = pin1_edge & ~PIN1_OUTPUT_ENABLE_IN & PIN1_STICKY_IN
                                 & ~PIN1_SECONDARY_CODEC_IN;
  assign pin_set[`HIA_PIN_VUP] = (vup_edge & VOL_UP_STICKY_IN) | vol_engine_up;
  assign pin_set[`HIA_PIN_VDN] = (vdn_edge & VOL_DOWN_STICKY_IN) | vol_engine_dn;
  assign pin_set[`HIA_PIN_GPP] = gpp_rise;
  assign pin_set[`HIA_PIN_GPS] = gps_rise;

  // Event latch vectors
  logic [`HIA_EV_COUNT-1:0] ev_set;
  logic [`HIA_EV_COUNT-1:0] ev_clear;
  logic [`HIA_EV_COUNT-1:0] ev_flag;

  assign ev_set[`HIA_EV_DMA_LSB-1:`HIA_EV_PIN_LSB] = pin_set;
  assign ev_set[`HIA_EV_FIFO_LSB-1:`HIA_EV_DMA_LSB] = DMA_EVENT_IN;
  assign ev_set[`HIA_EV_MIDI-1:`HIA_EV_FIFO_LSB] = FIFO_EVENT_IN;
  // MIDI flag set on received data
  assign ev_set[`HIA_EV_MIDI] = MIDI_RX_DATA_IN;

  // Pin flags cleared only by control write
  assign ev_clear[`HIA_EV_DMA_LSB-1:`HIA_EV_PIN_LSB] = PIN_EVENT_CLEAR_IN;
  // Engine status read clears its bit
  assign ev_clear[`HIA_EV_FIFO_LSB-1:`HIA_EV_DMA_LSB] = DMA_STATUS_READ_IN;
  // FIFO status read clears its bit
  assign ev_clear[`HIA_EV_MIDI-1:`HIA_EV_FIFO_LSB] = FIFO_IRQ_STATUS_READ_IN;
  assign ev_clear[`HIA_EV_MIDI] = MIDI_PORT_STATUS_READ_IN;

  hia_event_latch #(
    .WIDTH(`HIA_EV_COUNT)
  ) u_events (
    .clk_in(CORE_CLK_IN),
    .srst_in(SRST_IN),
    .set_in(ev_set),
    .clear_in(ev_clear),
    .flag_out(ev_flag)
  );

  // Masked views; a masked source is not reported so the status shows what raised the line
  logic [5:0] pin_vis;
  logic [3:0] dma_vis;
  logic [3:0] fifo_vis;
  logic midi_vis;
  logic dma_sum;
  logic fifo_sum;
  logic any_source;
  logic dma_group_mask;
  logic fifo_group_mask;

  // A one in the mask blocks the source
  // Volume masks apply in every pin use
  assign pin_vis = ev_flag[`HIA_EV_DMA_LSB-1:`HIA_EV_PIN_LSB]
                   & ~mask_q[`HIA_PIN_LSB+5:`HIA_PIN_LSB];
  assign dma_group_mask = mask_q[`HIA_BIT_DMA_SUM];
  assign fifo_group_mask = mask_q[`HIA_BIT_FIFO_SUM];
  assign dma_vis = ev_flag[`HIA_EV_FIFO_LSB-1:`HIA_EV_DMA_LSB]
                   & ~mask_q[`HIA_DMA_LSB+3:`HIA_DMA_LSB] & {4{~dma_group_mask}};
  assign fifo_vis = ev_flag[`HIA_EV_MIDI-1:`HIA_EV_FIFO_LSB]
                    & ~mask_q[`HIA_FIFO_LSB+3:`HIA_FIFO_LSB] & {4{~fifo_group_mask}};
  assign midi_vis = ev_flag[`HIA_EV_MIDI] & ~mask_q[`HIA_BIT_MIDI];
  // Summary is OR of per-FIFO bits
  assign fifo_sum = |fifo_vis;
  assign dma_sum = |dma_vis;
  assign any_source = |pin_vis | dma_sum | fifo_sum | midi_vis;

  // Status word
  hia_word_t status_word;
  always_comb begin
    status_word = `HIA_ZERO_WORD;
    status_word[`HIA_BIT_ENABLE] = enable_q;
    status_word[`HIA_BIT_MIDI] = midi_vis;
    status_word[`HIA_BIT_FIFO_SUM] = fifo_sum;
    status_word[`HIA_BIT_DMA_SUM] = dma_sum;
    status_word[`HIA_FIFO_LSB+3:`HIA_FIFO_LSB] = fifo_vis;
    status_word[`HIA_DMA_LSB+3:`HIA_DMA_LSB] = dma_vis;
    status_word[`HIA_PIN_LSB+5:`HIA_PIN_LSB] = pin_vis;
  end

  hia_word_t cmd_word;
  // Enable in bit 0, strobe reads zero
  always_comb begin
    cmd_word = `HIA_ZERO_WORD;
    cmd_word[`HIA_CMD_VALUE_BIT] = enable_q;
  end

  // Global enable next value
  // A strobed write beats a status read in the same cycle
  always_comb begin
    enable_d = enable_q;
    if (wr_cmd && cmd_strobe) begin
      enable_d = cmd_value;
    end else if (rd_status && any_source) begin
      // Clear only with a pending source
      enable_d = 1'b0;
    end
  end

  // Reserved mask bits are kept as written; software must write zeros there
  assign mask_d = wr_mask ? REG_WDATA_IN : mask_q;

  // Read data; unmapped offsets read zero
  always_comb begin
    rdata_d = `HIA_ZERO_WORD;
    if (rd_status) begin
      // Pre-clear enable is what this read returns
      rdata_d = status_word;
    end else if (rd_cmd) begin
      rdata_d = cmd_word;
    end else if (rd_mask) begin
      rdata_d = mask_q;
    end
  end

  // Line gated by the global enable
  // Active-low level output
  // Built from the next enable so a clearing read drops the line at once
  assign irq_n_d = ~(enable_d & any_source);

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      enable_q <= 1'b0;
      mask_q <= `HIA_MASK_RESET;
      rdata_q <= `HIA_ZERO_WORD;
      rvalid_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      enable_q <= enable_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      // Every read gets an answer, unmapped offsets included
      rvalid_q <= REG_RD_IN;
      // Registered so the host line cannot glitch while flags settle
      irq_n_q <= irq_n_d;
    end
  end

  // History starts invalid so a level present at reset release is not an edge
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      hist_valid_q <= 1'b0;
      pin3_prev_q <= 1'b0;
      pin1_prev_q <= 1'b0;
      vup_prev_q <= 1'b0;
      vdn_prev_q <= 1'b0;
      gpp_prev_q <= 1'b0;
      gps_prev_q <= 1'b0;
    end else begin
      hist_valid_q <= 1'b1;
      pin3_prev_q <= PIN3_IN;
      pin1_prev_q <= PIN1_IN;
      vup_prev_q <= VOL_UP_PIN_IN;
      vdn_prev_q <= VOL_DOWN_PIN_IN;
      gpp_prev_q <= PRIMARY_GP_INT_IN;
      gps_prev_q <= SECONDARY_GP_INT_IN;
    end
  end

  assign REG_RDATA_OUT = rdata_q;
  assign REG_RVALID_OUT = rvalid_q;
  // Raw flags, unmasked, for the pin event control readback
  assign PIN_STICKY_STATUS_OUT = ev_flag[`HIA_EV_DMA_LSB-1:`HIA_EV_PIN_LSB];
  assign HOST_IRQ_N_OUT = irq_n_q;

endmodule

// >>> hia_checker.sv
// Port assertions for the host interrupt aggregator
`timescale 1ns/10ps
module hia_checker (
  input wire logic CORE_CLK_IN,
  input wire logic SRST_IN,
  input wire logic [11:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic [31:0] REG_RDATA_OUT,
  input wire logic REG_RVALID_OUT,
  input wire logic [5:0] PIN_EVENT_CLEAR_IN,
  input wire logic [5:0] PIN_STICKY_STATUS_OUT,
  input wire logic HOST_IRQ_N_OUT
);
  logic [5:0] keep_q;
  wire st_rd = REG_RD_IN && !REG_WR_IN && REG_ADDR_IN == 12'h000;
  wire cmd_wr = REG_WR_IN && !REG_RD_IN && REG_ADDR_IN == 12'h008;
  wire mask_wr = REG_WR_IN && !REG_RD_IN && REG_ADDR_IN == 12'h00C;
  wire mask_rd = REG_RD_IN && !REG_WR_IN && REG_ADDR_IN == 12'h00C;
  wire unmapped = !(REG_ADDR_IN inside {12'h000, 12'h008, 12'h00C});
  // Flags that had no clear strobe must still be set next cycle
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      keep_q <= 6'h00;
    end else begin
      keep_q <= PIN_STICKY_STATUS_OUT & ~PIN_EVENT_CLEAR_IN;
    end
  end
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SRST_IN);
  sequence s_status_rd;
    st_rd;
  endsequence
  sequence s_src_seen;
    REG_RDATA_OUT[22:0] != 23'h000000;
  endsequence
  a_read_answer: assert property (REG_RD_IN |=> REG_RVALID_OUT)
    else $error("read got no answer");
  a_answer_cause: assert property (REG_RVALID_OUT |-> $past(REG_RD_IN))
    else $error("answer without read");
  a_idle_zero: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 32'h00000000)
    else $error("read data not zero when idle");
  a_cmd_read_form: assert property (REG_RD_IN && REG_ADDR_IN == 12'h008 |=>
    REG_RDATA_OUT[31:1] == 31'h00000000) else $error("command read upper bits set");
  a_unmapped_zero: assert property (REG_RD_IN && unmapped |=> REG_RDATA_OUT == 32'h00000000)
    else $error("unmapped read not zero");
  a_disable_line: assert property (cmd_wr && REG_WDATA_IN[1:0] == 2'b10 |=>
    HOST_IRQ_N_OUT) else $error("line active after disable");
  a_read_drops_line: assert property (s_status_rd ##1 s_src_seen |-> HOST_IRQ_N_OUT)
    else $error("line active after status read");
  a_second_read_off: assert property (s_status_rd ##1 (REG_RDATA_OUT[22:0] != 23'h000000 &&
    st_rd) |=> !REG_RDATA_OUT[31]) else $error("enable shown on second read");
  a_mask_echo: assert property (mask_wr ##1 !REG_WR_IN ##1 mask_rd |=>
    REG_RDATA_OUT == $past(REG_WDATA_IN, 3)) else $error("mask readback differs");
  a_pin_hold: assert property ((PIN_STICKY_STATUS_OUT & keep_q) == keep_q)
    else $error("pin flag lost without clear");
endmodule
bind hia_top hia_checker hia_checker_inst (.*);

// >>> hia_host_model.sv
// Host software model: register accesses and pin clear strobes
`timescale 1ns/10ps
module hia_host_model (
  input wire logic clk_in,
  input wire logic [31:0] rdata_in,
  input wire logic rvalid_in,
  output logic [11:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [31:0] wdata_out,
  output logic [5:0] clr_out
);
  initial begin
    {addr_out, wr_out, rd_out, wdata_out, clr_out} = '0;
  end
  // Trailing idle cycle keeps strobes from being raised in the step they drop
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    addr_out = a;
    wdata_out = v;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~v;
    @(negedge clk_in);
  endtask
  task automatic rd2(input logic [11:0] a, output logic [31:0] d, output logic [31:0] e);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    d = rvalid_in ? rdata_in : 32'hX;
    @(negedge clk_in);
    e = rvalid_in ? rdata_in : 32'hX;
    rd_out = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    d = rvalid_in ? rdata_in : 32'hX;
    rd_out = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic end_of_interrupt();
    wr(12'h008, 32'h00000003);
  endtask
  task automatic off();
    wr(12'h008, 32'h00000002);
  endtask
  task automatic clr(input logic [5:0] b);
    clr_out = b;
    @(negedge clk_in);
    clr_out = 6'h00;
  endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the host interrupt aggregator
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] dev = '0, dsr = '0, fev = '0, fsr = '0, pin = '0, stk = '0;
  logic [1:0] oe = '0, lt = '0;
  logic mrx = 1'b0, mrd = 1'b0, gpp = 1'b0, gps = 1'b0, p1c = 1'b0, hve = 1'b0, hvu = 1'b0;
  logic [11:0] adr;
  logic [31:0] wd, rdat, d, e;
  logic wr, rd, rv, irq_n;
  logic [5:0] clr, pso;
  int mismatches = 0;
  int checked = 0;
  always #25 clk = ~clk;
  hia_top hia_top_inst (.CORE_CLK_IN(clk), .SRST_IN(rst), .REG_ADDR_IN(adr), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_WDATA_IN(wd), .REG_RDATA_OUT(rdat), .REG_RVALID_OUT(rv),
    .DMA_EVENT_IN(dev), .DMA_STATUS_READ_IN(dsr), .FIFO_EVENT_IN(fev),
    .FIFO_IRQ_STATUS_READ_IN(fsr), .MIDI_RX_DATA_IN(mrx), .MIDI_PORT_STATUS_READ_IN(mrd),
    .PRIMARY_GP_INT_IN(gpp), .SECONDARY_GP_INT_IN(gps), .PIN3_IN(pin[3]), .PIN1_IN(pin[2]),
    .VOL_UP_PIN_IN(pin[1]), .VOL_DOWN_PIN_IN(pin[0]), .PIN3_OUTPUT_ENABLE_IN(oe[1]),
    .PIN1_OUTPUT_ENABLE_IN(oe[0]), .PIN3_STICKY_IN(stk[3]), .PIN1_STICKY_IN(stk[2]),
    .VOL_UP_STICKY_IN(stk[1]), .VOL_DOWN_STICKY_IN(stk[0]), .VOL_UP_LATCH_TRIGGER_IN(lt[1]),
    .VOL_DOWN_LATCH_TRIGGER_IN(lt[0]), .PIN1_SECONDARY_CODEC_IN(p1c),
    .HW_VOLUME_ENABLE_IN(hve), .HW_VOLUME_UPDATE_IN(hvu), .PIN_EVENT_CLEAR_IN(clr),
    .PIN_STICKY_STATUS_OUT(pso), .HOST_IRQ_N_OUT(irq_n));
  hia_host_model hia_host_model_inst (.clk_in(clk), .rdata_in(rdat), .rvalid_in(rv),
    .addr_out(adr), .wr_out(wr), .rd_out(rd), .wdata_out(wd), .clr_out(clr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic w(input logic [11:0] a, input logic [31:0] v);
    hia_host_model_inst.wr(a, v);
  endtask
  task automatic rr(input logic [11:0] a, input logic [31:0] exp);
    hia_host_model_inst.rd(a, d);
    chk(d, exp);
  endtask
  task automatic t_defaults;
    rr(12'h00C, 32'h00F4FF3F);
    rr(12'h008, 32'h00000000);
    w(12'h000, 32'hFFFFFFFF);
    rr(12'h000, 32'h00000000);
    rr(12'h010, 32'h00000000);
    w(12'h00C, 32'h12345678);
    rr(12'h00C, 32'h12345678);
    chk({31'h0, irq_n}, 32'h1);
  endtask
  task automatic t_dma;
    w(12'h00C, 32'h0);
    hia_host_model_inst.end_of_interrupt();
    dev = 4'h4;
    tk(1);
    dev = 4'h0;
    tk(1);
    chk({31'h0, irq_n}, 32'h0);
    hia_host_model_inst.rd2(12'h000, d, e);
    chk(d, 32'h80040400);
    chk(e, 32'h00040400);
    chk({31'h0, irq_n}, 32'h1);
    w(12'h008, 32'h1);
    rr(12'h008, 32'h0);
    w(12'h00C, 32'h00040000);
    rr(12'h000, 32'h0);
    dsr = 4'h4;
    tk(1);
    dsr = 4'h0;
    w(12'h00C, 32'h0);
    rr(12'h000, 32'h0);
  endtask
  task automatic t_fifo;
    hia_host_model_inst.end_of_interrupt();
    rr(12'h008, 32'h1);
    hia_host_model_inst.off();
    fev = 4'h3;
    tk(1);
    fev = 4'h0;
    tk(1);
    chk({31'h0, irq_n}, 32'h1);
    w(12'h00C, 32'h00001000);
    rr(12'h000, 32'h00102000);
    fsr = 4'h2;
    tk(1);
    fsr = 4'h0;
    rr(12'h000, 32'h0);
    w(12'h00C, 32'h0);
    rr(12'h000, 32'h00101000);
    fsr = 4'h1;
    tk(1);
    fsr = 4'h0;
    rr(12'h000, 32'h0);
  endtask
  task automatic t_midi;
    mrx = 1'b1;
    tk(2);
    hia_host_model_inst.end_of_interrupt();
    chk({31'h0, irq_n}, 32'h0);
    mrx = 1'b0;
    rr(12'h000, 32'h80400000);
    mrd = 1'b1;
    tk(1);
    mrd = 1'b0;
    rr(12'h000, 32'h0);
  endtask
  task automatic t_pins;
    stk = 4'hF;
    oe = 2'b10;
    p1c = 1'b1;
    pin = 4'hC;
    tk(2);
    chk({26'h0, pso}, 32'h0);
    oe = 2'b00;
    p1c = 1'b0;
    pin = 4'h3;
    tk(2);
    chk({26'h0, pso}, 32'h0F);
    hia_host_model_inst.clr(6'h0C);
    chk({26'h0, pso}, 32'h03);
    w(12'h00C, 32'h2);
    rr(12'h000, 32'h1);
    hia_host_model_inst.clr(6'h03);
    stk = 4'h0;
    hve = 1'b1;
    lt = 2'b11;
    hvu = 1'b1;
    tk(1);
    hvu = 1'b0;
    tk(1);
    chk({26'h0, pso}, 32'h03);
    hia_host_model_inst.clr(6'h03);
    gpp = 1'b1;
    gps = 1'b1;
    tk(2);
    chk({26'h0, pso}, 32'h30);
    hia_host_model_inst.clr(6'h30);
    chk({26'h0, pso}, 32'h0);
  endtask
  initial begin
    tk(16);
    rst = 1'b0;
    tk(1);
    t_defaults();
    t_dma();
    t_fifo();
    t_midi();
    t_pins();
    give_verdict();
  end
endmodule
